// ---- shared/wdog_map.svh ----
// wdog_map.svh: offsets-free constant map for the load gated edge watchdog
// assumes: 100 MHz clock, current and capacitance given as digital codes
`ifndef WDOG_MAP_SVH
`define WDOG_MAP_SVH

// ------------------------------------------------------------
// clock and time base
// ------------------------------------------------------------
`define WD_CLK_PERIOD_NS 10
`define WD_TICK_US 10
`define WD_TICK_CYCLES ((`WD_TICK_US * 1000) / `WD_CLK_PERIOD_NS)

// ------------------------------------------------------------
// timing at reference capacitance
// ------------------------------------------------------------
`define WD_REF_CAP_NF 100
`define WD_CAP_MIN_NF 10
`define WD_TRIG_TIME_US 36000
`define WD_LOW_TIME_US 18000
`define WD_TRIG_TICKS_PER_NF (`WD_TRIG_TIME_US / (`WD_REF_CAP_NF * `WD_TICK_US))
`define WD_LOW_TICKS_PER_NF (`WD_LOW_TIME_US / (`WD_REF_CAP_NF * `WD_TICK_US))

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define WD_CAP_W 16
`define WD_CUR_W 16
`define WD_SEL_W 4
`define WD_CNT_W 22
`define WD_PRE_W 16

// ------------------------------------------------------------
// default activation pair in microamps, adjust pin open
// ------------------------------------------------------------
`define WD_ACT_DEF_UA 1100
`define WD_DEACT_DEF_UA 900

`endif

// ---- shared/wdog_pkg.sv ----
// wdog_pkg: types of the load gated edge watchdog
// assumes: wdog_map.svh on the include path
`include "wdog_map.svh"

package wdog_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WINDOW = 3'b010,
      ST_LOW = 3'b100
   } wd_state_e;

   typedef struct packed {
      logic prev;
      logic pulse;
   } edge_s;

   typedef struct packed {
      wd_state_e st;
      logic armed;
      logic [`WD_CNT_W-1:0] cnt;
      logic [`WD_PRE_W-1:0] pre;
      logic fault_oe;
      logic fault_out;
      logic window_active;
   } wd_core_s;

endpackage

// ---- hw/rise_detect.sv ----
// rise_detect: one-cycle pulse on each rising edge of a synchronous input
// assumes: input already synchronous to i_clk
`timescale 1ns/1ps

module rise_detect
   import wdog_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_level,
   output logic o_pulse
);

   edge_s r;
   edge_s next_r;

   always_comb begin
      next_r = r;
      next_r.prev = i_level;
      next_r.pulse = i_level & ~r.prev;
   end

   // prev resets high so a level already high is no edge
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         r <= '{prev: 1'b1, pulse: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign o_pulse = r.pulse;

endmodule

// ---- hw/load_gated_edge_watchdog.sv ----
// load_gated_edge_watchdog: trigger window supervisor gated by load current
// assumes: load current in microamps and capacitance in nanofarads arrive
// as synchronous codes; reset output and its wiring live outside
`timescale 1ns/1ps
`include "wdog_map.svh"

module load_gated_edge_watchdog
   import wdog_pkg::*;
#(
   parameter int TICK_CYCLES = `WD_TICK_CYCLES
)
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_watchdog_trigger_input,
   input wire logic [`WD_CUR_W-1:0] i_load_current_ua,
   input wire logic [`WD_SEL_W-1:0] i_activation_threshold_adjust_pin,
   input wire logic [`WD_CAP_W-1:0] i_timing_cap_nf,
   output logic o_watchdog_fault_output_out,
   output logic o_watchdog_fault_output_oe,
   output logic o_armed,
   output logic o_window_active
);

   // ------------------------------------------------------------
   // threshold pair lookup
   // ------------------------------------------------------------
   // code 0 is the open pin; 1..9 are resistors from 4000k down to 7.5k
   function automatic logic [2*`WD_CUR_W-1:0] thresh_pair(
      input logic [`WD_SEL_W-1:0] sel
   );
      logic [2*`WD_CUR_W-1:0] p;
      begin
         case (sel)
            4'h1: p = {16'h03F7, 16'h03DB}; // 4000k 1015/987
            4'h2: p = {16'h053B, 16'h051E}; // 470k 1339/1310
            4'h3: p = {16'h06E1, 16'h06A4}; // 220k 1761/1700
            4'h4: p = {16'h0AA8, 16'h0A34}; // 100k 2728/2612
            4'h5: p = {16'h1153, 16'h1079}; // 50k 4435/4217
            4'h6: p = {16'h18BD, 16'h1780}; // 33k 6333/6016
            4'h7: p = {16'h2640, 16'h245E}; // 20k 9792/9310
            4'h8: p = {16'h485B, 16'h45AE}; // 10k 18523/17838
            4'h9: p = {16'h5E86, 16'h5BB0}; // 7.5k 24198/23472
            default: p = {16'(`WD_ACT_DEF_UA), 16'(`WD_DEACT_DEF_UA)};
         endcase
         thresh_pair = p;
      end
   endfunction

   // ------------------------------------------------------------
   // capacitance scaled tick counts
   // ------------------------------------------------------------
   // below the minimum the linear law breaks down, so clamp
   function automatic logic [`WD_CNT_W-1:0] scaled_ticks(
      input logic [`WD_CAP_W-1:0] cap,
      input logic [`WD_CNT_W-1:0] per_nf
   );
      logic [`WD_CNT_W-1:0] c;
      logic [2*`WD_CNT_W-1:0] prod;
      begin
         c = `WD_CNT_W'(cap);
         if (cap < `WD_CAP_W'(`WD_CAP_MIN_NF)) begin
            c = `WD_CNT_W'(`WD_CAP_MIN_NF);
         end
         prod = c * per_nf;
         scaled_ticks = prod[`WD_CNT_W-1:0];
      end
   endfunction

   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   wd_core_s r;
   wd_core_s next_r;
   logic trig_pulse;
   logic [2*`WD_CUR_W-1:0] pair;
   logic [`WD_CUR_W-1:0] act_ua;
   logic [`WD_CUR_W-1:0] deact_ua;
   logic arm_next;
   logic tick;
   logic [`WD_CNT_W-1:0] win_ticks;
   logic [`WD_CNT_W-1:0] low_ticks;

   // ------------------------------------------------------------
   // trigger edge detection
   // ------------------------------------------------------------
   rise_detect u_rise (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_level(i_watchdog_trigger_input),
      .o_pulse(trig_pulse)
   );

   // ------------------------------------------------------------
   // arming with hysteresis
   // ------------------------------------------------------------
   always_comb begin
      pair = thresh_pair(i_activation_threshold_adjust_pin);
      act_ua = pair[2*`WD_CUR_W-1:`WD_CUR_W];
      deact_ua = pair[`WD_CUR_W-1:0];
      if (r.armed) begin
         arm_next = (i_load_current_ua >= deact_ua);
      end else begin
         arm_next = (i_load_current_ua > act_ua);
      end
   end

   // ------------------------------------------------------------
   // time base and limits
   // ------------------------------------------------------------
   always_comb begin
      tick = (r.pre == `WD_PRE_W'(TICK_CYCLES - 1));
      win_ticks = scaled_ticks(i_timing_cap_nf, `WD_CNT_W'(`WD_TRIG_TICKS_PER_NF));
      low_ticks = scaled_ticks(i_timing_cap_nf, `WD_CNT_W'(`WD_LOW_TICKS_PER_NF));
   end

   // ------------------------------------------------------------
   // supervisor sequence
   // ------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.armed = arm_next;
      next_r.fault_out = 1'b0;
      if (tick) begin
         next_r.pre = '0;
      end else begin
         next_r.pre = r.pre + `WD_PRE_W'(1);
      end

      case (r.st)
         ST_IDLE: begin
            next_r.fault_oe = 1'b0;
            next_r.window_active = 1'b0;
            next_r.pre = '0;
            if (arm_next) begin
               // fresh window, nothing left from before
               next_r.st = ST_WINDOW;
               next_r.cnt = win_ticks;
               next_r.window_active = 1'b1;
            end
         end
         ST_WINDOW: begin
            if (trig_pulse) begin
               // service restarts the window, also on the expiry tick
               next_r.cnt = win_ticks;
               next_r.pre = '0;
            end else if (tick) begin
               if (r.cnt <= `WD_CNT_W'(1)) begin
                  next_r.st = ST_LOW;
                  next_r.cnt = low_ticks;
                  next_r.fault_oe = 1'b1;
                  next_r.window_active = 1'b0;
               end else begin
                  next_r.cnt = r.cnt - `WD_CNT_W'(1);
               end
            end
         end
         ST_LOW: begin
            // edges during the low time are ignored
            if (tick) begin
               if (r.cnt <= `WD_CNT_W'(1)) begin
                  next_r.st = ST_WINDOW;
                  next_r.cnt = win_ticks;
                  next_r.fault_oe = 1'b0;
                  next_r.window_active = 1'b1;
               end else begin
                  next_r.cnt = r.cnt - `WD_CNT_W'(1);
               end
            end
         end
         default: begin
            next_r.st = ST_IDLE;
            next_r.fault_oe = 1'b0;
            next_r.window_active = 1'b0;
         end
      endcase

      // disarm has priority in every state
      if (!arm_next) begin
         next_r.st = ST_IDLE;
         next_r.fault_oe = 1'b0;
         next_r.window_active = 1'b0;
         next_r.cnt = '0;
         next_r.pre = '0;
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         r <= '{st: ST_IDLE, armed: 1'b0, cnt: '0, pre: '0,
                fault_oe: 1'b0, fault_out: 1'b0, window_active: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------
   // outputs, all from flops
   // ------------------------------------------------------------
   // no reset path feeds the fault driver
   assign o_watchdog_fault_output_out = r.fault_out;
   assign o_watchdog_fault_output_oe = r.fault_oe;
   assign o_armed = r.armed;
   assign o_window_active = r.window_active;

endmodule

// ---- dv/wdog_properties.sv ----
// checker for the load gated watchdog, bound to its top module
// assumes: wdog_map.svh on the include path, tick length from the bind
`timescale 1ns/1ps
`include "wdog_map.svh"
module wdog_checker #(
   parameter int TICK_CYCLES = 4
)
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_watchdog_trigger_input,
   input wire logic [`WD_CUR_W-1:0] i_load_current_ua,
   input wire logic [`WD_SEL_W-1:0] i_activation_threshold_adjust_pin,
   input wire logic [`WD_CAP_W-1:0] i_timing_cap_nf,
   input wire logic o_watchdog_fault_output_out,
   input wire logic o_watchdog_fault_output_oe,
   input wire logic o_armed,
   input wire logic o_window_active
);
   logic oe;
   logic sel0;
   logic [31:0] lo_len;
   logic [31:0] lo_exp;
   assign oe = o_watchdog_fault_output_oe;
   assign sel0 = i_activation_threshold_adjust_pin == 4'h0;
   // small capacitors clamp to the minimum
   assign lo_exp = 18 * ((i_timing_cap_nf < 16'h000a) ? 32'h0000_000a : 32'(i_timing_cap_nf)) * TICK_CYCLES;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) lo_len <= '0;
      else lo_len <= oe ? lo_len + 1 : '0;
   end
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   sequence low_end;
      o_armed && $fell(oe);
   endsequence
   AST_OUT_LOW: assert property (o_watchdog_fault_output_out == 1'b0) else $error("fault data not low");
   AST_IDLE_REL: assert property (!o_armed |-> !oe) else $error("pulled low while idle");
   AST_ARM_FRESH: assert property ($rose(o_armed) |-> o_window_active && !oe) else $error("no fresh window");
   AST_ARM_DEF: assert property (sel0 && !o_armed && i_load_current_ua > 16'h044c |=> o_armed)
      else $error("not armed above threshold");
   AST_HOLD_DEF: assert property (sel0 && !o_armed && i_load_current_ua <= 16'h044c |=> !o_armed)
      else $error("armed below threshold");
   AST_DISARM_DEF: assert property (sel0 && o_armed && i_load_current_ua < 16'h0384 |=> !o_armed && !oe)
      else $error("not disarmed");
   AST_LOW_NO_WIN: assert property (oe |-> !o_window_active) else $error("window during low time");
   AST_EXPIRE: assert property ($rose(oe) |-> $past(o_window_active)) else $error("low without window");
   AST_LOW_TIME: assert property (low_end |-> lo_len == lo_exp) else $error("low time length off");
   AST_RESTART: assert property (low_end |-> o_window_active) else $error("no window after low");
endmodule

bind load_gated_edge_watchdog wdog_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.i_clk(i_clk), .i_nrst(i_nrst),
   .i_watchdog_trigger_input(i_watchdog_trigger_input), .i_load_current_ua(i_load_current_ua),
   .i_activation_threshold_adjust_pin(i_activation_threshold_adjust_pin), .i_timing_cap_nf(i_timing_cap_nf),
   .o_watchdog_fault_output_out(o_watchdog_fault_output_out), .o_watchdog_fault_output_oe(o_watchdog_fault_output_oe),
   .o_armed(o_armed), .o_window_active(o_window_active));

// ---- dv/mcu_trigger_model.sv ----
// controller model sending one trigger pulse per period
// assumes: period given in clock cycles, above 10
`timescale 1ns/1ps
module mcu_trigger_model (
   input wire logic i_clk,
   input wire logic i_en,
   input wire logic [15:0] i_period,
   output logic o_trig
);
   logic [15:0] cnt = 16'h0000;
   initial o_trig = 1'b0;
   // ------------------------------------------------------------
   // pulse generator, rising edge opens each period
   // ------------------------------------------------------------
   always @(posedge i_clk) begin
      cnt <= (!i_en || cnt >= i_period - 1) ? 16'h0000 : cnt + 1;
      o_trig <= i_en && cnt < 16'h000a;
   end
endmodule

// ---- dv/load_gated_edge_watchdog_tb.sv ----
// testbench of the load gated watchdog with a controller model
// assumes: short tick parameter, 100 MHz clock
`timescale 1ns/1ps
module load_gated_edge_watchdog_tb;
   localparam int T = 4;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic en = 1'b0;
   logic trig, out, oe, armed, win;
   logic [15:0] cur = 16'h0000;
   logic [15:0] cap = 16'h000a;
   logic [15:0] per = 16'h03e8;
   logic [3:0] sel = 4'h0;
   int errors = 0;
   int n_compared = 0;
   int act[10] = '{1100, 1015, 1339, 1761, 2728, 4435, 6333, 9792, 18523, 24198};
   int deact[10] = '{900, 987, 1310, 1700, 2612, 4217, 6016, 9310, 17838, 23472};
   always #5 i_clk = ~i_clk;
   mcu_trigger_model mdl_u (.i_clk(i_clk), .i_en(en), .i_period(per), .o_trig(trig));
   load_gated_edge_watchdog #(.TICK_CYCLES(T)) dut_u (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_watchdog_trigger_input(trig), .i_load_current_ua(cur), .i_activation_threshold_adjust_pin(sel),
      .i_timing_cap_nf(cap), .o_watchdog_fault_output_out(out), .o_watchdog_fault_output_oe(oe),
      .o_armed(armed), .o_window_active(win));
   // ------------------------------------------------------------
   // helpers and scenarios
   // ------------------------------------------------------------
   task automatic chk(string nm, int lo, int hi, logic [31:0] got);
      n_compared++;
      if (^got === 1'bx || got < lo || got > hi) begin
         errors++;
         $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      end
   endtask
   task automatic step(int c);
      repeat (c) @(posedge i_clk);
      #1;
   endtask
   task automatic set_cur(logic [15:0] v);
      @(posedge i_clk);
      cur <= v;
      step(1);
   endtask
   task automatic count_until(bit pick_win, logic val, output int n);
      n = 0;
      while ((pick_win ? win : oe) !== val && n < 40000) begin
         step(1);
         n++;
      end
   endtask
   task automatic t_thresholds;
      for (int i = 0; i < 11; i++) begin
         @(posedge i_clk);
         sel <= (i == 10) ? 4'hc : 4'(i);
         set_cur(16'h0000);
         set_cur(16'(act[i % 10]));
         chk("armed at act", 0, 0, armed);
         set_cur(16'(act[i % 10] + 1));
         chk("armed above act", 1, 1, armed);
         set_cur(16'(deact[i % 10]));
         chk("armed at deact", 1, 1, armed);
         set_cur(16'(deact[i % 10] - 1));
         chk("armed below deact", 0, 0, armed);
      end
   endtask
   task automatic t_service;
      int n;
      n = 0;
      @(posedge i_clk);
      sel <= 4'h0;
      en <= 1'b1;
      set_cur(16'h07d0);
      repeat (6000) begin
         step(1);
         n += oe;
      end
      chk("fault while serviced", 0, 0, n);
      en <= 1'b0;
      set_cur(16'h0000);
   endtask
   task automatic t_miss(logic [15:0] c);
      int ce, n;
      ce = (c < 10) ? 10 : c;
      @(posedge i_clk);
      cap <= c;
      set_cur(16'h07d0);
      count_until(1'b0, 1'b1, n);
      chk("window length", 36 * ce * T, 36 * ce * T + 2, n);
      count_until(1'b0, 1'b0, n);
      chk("low length", 18 * ce * T, 18 * ce * T + 1, n);
      chk("fault data", 0, 0, out);
      chk("window after low", 1, 1, win);
      count_until(1'b0, 1'b1, n);
      chk("second window", 36 * ce * T, 36 * ce * T + 2, n);
      set_cur(16'h0000);
   endtask
   task automatic wrap_up;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge i_clk);
      i_nrst <= 1'b1;
      step(2);
      t_thresholds;
      t_service;
      t_miss(16'h0005);
      t_miss(16'h0014);
      wrap_up;
   end
   initial begin
      #1_000_000;
      errors++;
      wrap_up;
   end
endmodule
